/* File: core/hpds_sequencer.sv */
// Local design decisions: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ps
`include "hpds_map.svh"
module hpds_sequencer #(
	parameter int unsigned TICK_CYC = `HPDS_TICK_CYC
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// thermostat and field pins
	input wire hpds_pkg::hpds_calls_t calls_i,
	input wire logic coil_frost_switch_i,
	input wire logic run_period_sel_a_i,
	input wire logic run_period_sel_b_i,
	input wire logic two_comp_sel_i,
	input wire logic speedup_short_i,
	// load relays
	output hpds_pkg::hpds_loads_t loads_o,
	// avalon-mm slave
	input wire logic [3:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o
);
	import hpds_pkg::*;

	logic [8:0] pins_sync;
	hpds_calls_t calls;
	logic frost_closed, sel_a, sel_b, two_comp, short_now;
	logic ds_tick, min_tick;
	hpds_state_t state_reg, state_next;
	logic valve_reg;
	logic [9:0] sub_reg;
	logic [7:0] elapsed_reg, period_min;
	logic [7:0] def_min_reg;
	logic [11:0] def_ds_reg;
	logic [11:0] short_cnt_reg;
	logic short_d_reg;
	logic test_reg, forced_reg, forced_open_reg, force_pend_reg;
	logic test_start, force_start;
	logic defrost_done, period_up;
	logic [31:0] ctrl_reg;
	logic ack_reg;
	logic enable;

	// all field pins are async to clk_i
	hpds_sync #(
		.W(9)
	) u_sync (
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.d_i({calls_i, coil_frost_switch_i, run_period_sel_a_i, run_period_sel_b_i,
			two_comp_sel_i, speedup_short_i}),
		.q_o(pins_sync)
	);
	assign calls = pins_sync[8:5];
	assign frost_closed = pins_sync[4];
	assign sel_a = pins_sync[3];
	assign sel_b = pins_sync[2];
	assign two_comp = pins_sync[1];
	assign short_now = pins_sync[0];

	// 0.1 s base tick; shorten TICK_CYC in simulation
	hpds_tick #(
		.DIV(TICK_CYC)
	) u_tick (
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.tick_o(ds_tick)
	);

	assign enable = ctrl_reg[`HPDS_CTRL_EN_BIT];

	// run period from the selector switches, both open means default
	always_comb begin
		case ({sel_b, sel_a})
			2'h1: period_min = `HPDS_RUN_SEL1_MIN;
			2'h2: period_min = `HPDS_RUN_SEL2_MIN;
			2'h3: period_min = `HPDS_RUN_SEL3_MIN;
			default: period_min = `HPDS_RUN_SEL0_MIN;
		endcase
	end

	// a minute is 600 ticks, or one tick in scaled mode
	assign min_tick = ds_tick && (test_reg || sub_reg == `HPDS_SUB_LAST);
	assign period_up = elapsed_reg >= period_min;

	// defrost termination; forced-open hold ignores the coil switch
	always_comb begin
		if (forced_open_reg) begin
			defrost_done = def_ds_reg >= `HPDS_FORCED_HOLD_DS;
		end else begin
			defrost_done = !frost_closed || def_min_reg >= `HPDS_DEFROST_MAX_MIN;
		end
		if (test_reg && def_ds_reg >= `HPDS_TEST_MAX_DS) begin
			defrost_done = 1'b1;
		end
	end

	// contact short length measured in ticks, judged on release
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			short_cnt_reg <= 12'h000;
			short_d_reg <= 1'b0;
		end else begin
			short_d_reg <= short_now;
			if (!short_now) begin
				short_cnt_reg <= 12'h000;
			end else if (ds_tick && short_cnt_reg != `HPDS_SHORT_SAT) begin
				short_cnt_reg <= short_cnt_reg + 12'h001;
			end
		end
	end
	// lengths outside both windows are ignored
	assign test_start = short_d_reg && !short_now &&
		short_cnt_reg >= `HPDS_TEST_SHORT_MIN_DS &&
		short_cnt_reg <= `HPDS_TEST_SHORT_MAX_DS;
	assign force_start = short_d_reg && !short_now &&
		short_cnt_reg >= `HPDS_FORCE_SHORT_MIN_DS &&
		short_cnt_reg <= `HPDS_FORCE_SHORT_MAX_DS;

	// mode state machine
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			HPDS_IDLE: begin
				if (calls.cool1) begin
					state_next = HPDS_COOL;
				end else if (calls.heat1) begin
					state_next = HPDS_HEAT;
				end
			end
			HPDS_COOL: begin
				if (!calls.cool1) begin
					state_next = HPDS_IDLE;
				end
			end
			HPDS_HEAT: begin
				if (!calls.heat1 || calls.cool1) begin
					state_next = HPDS_IDLE;
				end else if (force_pend_reg) begin
					state_next = HPDS_DEFROST;
				end else if (period_up && frost_closed) begin
					state_next = HPDS_DEFROST;
				end
			end
			HPDS_DEFROST: begin
				if (defrost_done) begin
					state_next = calls.heat1 ? HPDS_HEAT : HPDS_IDLE;
				end else if (!calls.heat1) begin
					state_next = HPDS_IDLE;
				end
			end
			default: state_next = HPDS_IDLE;
		endcase
		if (!enable) begin
			state_next = HPDS_IDLE;
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state_reg <= HPDS_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// valve latches its last mode through idle
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			valve_reg <= 1'b0;
		end else if (state_next == HPDS_COOL) begin
			valve_reg <= 1'b1;
		end else if (state_next == HPDS_HEAT) begin
			valve_reg <= 1'b0;
		end
	end

	// run period timer; cleared by a test start, otherwise holds its value while idle or cooling
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			sub_reg <= 10'h000;
			elapsed_reg <= 8'h00;
		end else if (test_start) begin
			sub_reg <= 10'h000;
			elapsed_reg <= 8'h00;
		end else if (state_reg == HPDS_DEFROST) begin
			sub_reg <= 10'h000;
			elapsed_reg <= 8'h00;
		end else if (state_reg == HPDS_HEAT) begin
			if (period_up && !frost_closed) begin
				elapsed_reg <= 8'h00;
			end else if (min_tick) begin
				elapsed_reg <= elapsed_reg + 8'h01;
			end
			if (ds_tick) begin
				sub_reg <= (sub_reg == `HPDS_SUB_LAST) ? 10'h000 : sub_reg + 10'h001;
			end
		end
	end

	// defrost length counters, cleared outside defrost
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			def_ds_reg <= 12'h000;
			def_min_reg <= 8'h00;
		end else if (state_reg != HPDS_DEFROST) begin
			def_ds_reg <= 12'h000;
			def_min_reg <= 8'h00;
		end else if (ds_tick) begin
			// ticks wrap each minute so the ten minute cap stays reachable
			if (def_ds_reg == 12'(`HPDS_SUB_LAST)) begin
				def_ds_reg <= 12'h000;
			end else begin
				def_ds_reg <= def_ds_reg + 12'h001;
			end
			// defrost minutes scale too; 30 s and 12 s limits fit inside one wrap
			if (test_reg || def_ds_reg == 12'(`HPDS_SUB_LAST)) begin
				def_min_reg <= def_min_reg + 8'h01;
			end
		end
	end

	// service modes; a forced request waits for a heating call
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			test_reg <= 1'b0;
			forced_reg <= 1'b0;
			forced_open_reg <= 1'b0;
			force_pend_reg <= 1'b0;
		end else begin
			if (test_start) begin
				test_reg <= 1'b1;
			end else if (state_reg == HPDS_DEFROST && state_next != HPDS_DEFROST) begin
				test_reg <= 1'b0;
			end
			if (force_start) begin
				force_pend_reg <= 1'b1;
			end else if (state_reg == HPDS_HEAT && state_next == HPDS_DEFROST) begin
				force_pend_reg <= 1'b0;
			end
			if (state_reg == HPDS_HEAT && state_next == HPDS_DEFROST) begin
				forced_reg <= force_pend_reg;
				forced_open_reg <= force_pend_reg && !frost_closed;
			end else if (state_reg == HPDS_DEFROST && state_next != HPDS_DEFROST) begin
				forced_reg <= 1'b0;
				forced_open_reg <= 1'b0;
			end
		end
	end

	// relay drives come from flops to avoid glitches on the contactors
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			loads_o <= '0;
		end else begin
			loads_o.comp1 <= state_reg != HPDS_IDLE;
			loads_o.comp2 <= state_reg == HPDS_COOL && two_comp && calls.cool2;
			loads_o.fan <= state_reg == HPDS_COOL || state_reg == HPDS_HEAT;
			loads_o.valve <= (state_reg == HPDS_DEFROST) || valve_reg;
			loads_o.aux_heat <= calls.aux || state_reg == HPDS_DEFROST;
		end
	end

	// avalon slave: one wait state per access
	assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack_reg;

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= (avs_read_i || avs_write_i) && !ack_reg;
		end
	end

	// control register write, byte lanes honoured
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ctrl_reg <= `HPDS_CTRL_RST;
		end else if (avs_write_i && ack_reg && avs_address_i == `HPDS_REG_CTRL) begin
			for (int b = 0; b < 4; b++) begin
				if (avs_byteenable_i[b]) begin
					ctrl_reg[b*8 +: 8] <= avs_writedata_i[b*8 +: 8];
				end
			end
		end
	end

	// read data captured while waitrequest is high; unmapped reads zero
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			avs_readdata_o <= 32'h00000000;
		end else if (avs_read_i && !ack_reg) begin
			case (avs_address_i)
				`HPDS_REG_CTRL: avs_readdata_o <= ctrl_reg;
				`HPDS_REG_STATUS: avs_readdata_o <= {20'h00000, state_reg, test_reg,
					forced_reg, force_pend_reg, valve_reg, 1'b0, loads_o};
				`HPDS_REG_ELAPSED: avs_readdata_o <= {8'h00, def_min_reg, period_min,
					elapsed_reg};
				default: avs_readdata_o <= 32'h00000000;
			endcase
		end
	end

	// checks
	valve_cool_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		state_reg == HPDS_COOL |=> loads_o.valve && loads_o.fan && loads_o.comp1)
		else $error("valve not on in cooling");
	valve_hold_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		state_reg == HPDS_IDLE && state_next == HPDS_IDLE |=> $stable(valve_reg))
		else $error("valve changed while idle");
	heat_loads_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		state_reg == HPDS_HEAT |=> !loads_o.valve && loads_o.fan && loads_o.comp1)
		else $error("wrong loads in heating");
	defrost_loads_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		state_reg == HPDS_DEFROST |=> !loads_o.fan && loads_o.valve && loads_o.aux_heat)
		else $error("wrong loads in defrost");
	comp2_cause_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		loads_o.comp2 |-> $past(two_comp && calls.cool2 && state_reg == HPDS_COOL))
		else $error("second compressor without cause");
	early_defrost_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		state_reg == HPDS_HEAT && state_next == HPDS_DEFROST && !force_pend_reg
		|-> period_up && frost_closed)
		else $error("defrost before run period");
	defrost_max_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		state_reg == HPDS_DEFROST && !forced_open_reg |-> def_min_reg <= `HPDS_DEFROST_MAX_MIN)
		else $error("defrost past its limit");
	forced_hold_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		state_reg == HPDS_DEFROST && forced_open_reg |-> def_ds_reg <= `HPDS_FORCED_HOLD_DS)
		else $error("forced defrost past 30 s");
	test_cap_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		state_reg == HPDS_DEFROST && test_reg |-> def_ds_reg <= `HPDS_TEST_MAX_DS)
		else $error("test defrost past 12 s");
	test_end_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		state_reg == HPDS_DEFROST && state_next != HPDS_DEFROST && !test_start |=> !test_reg)
		else $error("scaled mode outlived defrost");
endmodule

/* File: core/hpds_map.svh */
`ifndef HPDS_MAP_SVH
`define HPDS_MAP_SVH

// clock and base tick (0.1 s)
`define HPDS_CLK_NS 32'h00000019
`define HPDS_TICK_NS 32'h05F5E100
`define HPDS_TICK_CYC (`HPDS_TICK_NS / `HPDS_CLK_NS)

// tick scaling
`define HPDS_DS_PER_S 12'h00A
`define HPDS_DS_PER_MIN 10'h258
`define HPDS_SUB_LAST (`HPDS_DS_PER_MIN - 10'h001)

// run period selections, minutes
`define HPDS_RUN_SEL0_MIN 8'h3C
`define HPDS_RUN_SEL1_MIN 8'h1E
`define HPDS_RUN_SEL2_MIN 8'h5A
`define HPDS_RUN_SEL3_MIN 8'h78

// defrost limits
`define HPDS_DEFROST_MAX_MIN 8'h0A
`define HPDS_FORCED_HOLD_S 12'h01E
`define HPDS_FORCED_HOLD_DS (`HPDS_FORCED_HOLD_S * `HPDS_DS_PER_S)
`define HPDS_TEST_MAX_S 12'h00C
`define HPDS_TEST_MAX_DS (`HPDS_TEST_MAX_S * `HPDS_DS_PER_S)

// speed-up contact windows, seconds
`define HPDS_TEST_SHORT_MIN_DS (12'h001 * `HPDS_DS_PER_S)
`define HPDS_TEST_SHORT_MAX_DS (12'h003 * `HPDS_DS_PER_S)
`define HPDS_FORCE_SHORT_MIN_DS (12'h005 * `HPDS_DS_PER_S)
`define HPDS_FORCE_SHORT_MAX_DS (12'h014 * `HPDS_DS_PER_S)
`define HPDS_SHORT_SAT 12'hFFF

// register map (byte addresses)
`define HPDS_REG_CTRL 4'h0
`define HPDS_REG_STATUS 4'h4
`define HPDS_REG_ELAPSED 4'h8
`define HPDS_CTRL_RST 32'h00000001
`define HPDS_CTRL_EN_BIT 0

`endif

/* File: core/hpds_pkg.sv */
package hpds_pkg;
	// thermostat calls
	typedef struct packed {
		logic cool1;
		logic cool2;
		logic heat1;
		logic aux;
	} hpds_calls_t;

	// load relay drives
	typedef struct packed {
		logic comp1;
		logic comp2;
		logic fan;
		logic valve;
		logic aux_heat;
	} hpds_loads_t;

	typedef enum logic [1:0] {
		HPDS_IDLE,
		HPDS_COOL,
		HPDS_HEAT,
		HPDS_DEFROST
	} hpds_state_t;
endpackage

/* File: core/hpds_sync.sv */
`timescale 1ns/1ps
module hpds_sync #(
	parameter int W = 1
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// async level in, synced level out
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	logic [W-1:0] meta_reg;

	// two flops; first stage read only by the second
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			meta_reg <= '0;
			q_o <= '0;
		end else begin
			meta_reg <= d_i;
			q_o <= meta_reg;
		end
	end
endmodule

/* File: core/hpds_tick.sv */
`timescale 1ns/1ps
module hpds_tick #(
	parameter int unsigned DIV = 4
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// one-cycle pulse every DIV cycles
	output logic tick_o
);
	logic [31:0] cnt_reg;

	// free-running divider
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cnt_reg <= 32'h00000000;
			tick_o <= 1'b0;
		end else if (cnt_reg == 32'(DIV - 1)) begin
			cnt_reg <= 32'h00000000;
			tick_o <= 1'b1;
		end else begin
			cnt_reg <= cnt_reg + 32'h00000001;
			tick_o <= 1'b0;
		end
	end
endmodule

/* File: bench/hpds_field.sv */
`timescale 1ns/1ps
module hpds_field (
	// clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// bench commands
	input wire hpds_pkg::hpds_calls_t want_i,
	input wire logic frost_i,
	input wire logic [15:0] melt_i,
	input wire logic short_i,
	// relay drives seen at the unit
	input wire hpds_pkg::hpds_loads_t loads_i,
	// pins into the board
	output hpds_pkg::hpds_calls_t calls_o,
	output logic coil_o,
	output logic short_o
);
	import hpds_pkg::*;
	logic [15:0] melt_reg;
	// coil warms only while the unit runs reversed with the fan off
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			melt_reg <= 16'h0000;
		end else if (!frost_i) begin
			melt_reg <= 16'h0000;
		end else if (loads_i.valve && loads_i.comp1 && !loads_i.fan && melt_reg != 16'hFFFF) begin
			melt_reg <= melt_reg + 16'h0001;
		end
	end
	// pins lag the bench by a clock, like a slow field switch
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			calls_o <= '0;
			short_o <= 1'b0;
			coil_o <= 1'b0;
		end else begin
			calls_o <= want_i;
			short_o <= short_i;
			coil_o <= frost_i && (melt_reg < melt_i);
		end
	end
endmodule

/* File: bench/heat_pump_defrost_sequencer_tb.sv */
`timescale 1ns/1ps
module heat_pump_defrost_sequencer_tb;
	import hpds_pkg::*;
	localparam int TC = 2;
	logic clk_i = 1'b0;
	logic nrst_i = 1'b0;
	hpds_calls_t want = '0;
	hpds_calls_t calls;
	hpds_loads_t loads;
	logic frost = 1'b0, coil, shrt = 1'b0, spin, sel_a = 1'b0, sel_b = 1'b0, two = 1'b0;
	logic [15:0] melt = 16'hFFFF;
	logic [3:0] adr = 4'h0, be = 4'hF;
	logic rd = 1'b0, wr = 1'b0, wt;
	logic [31:0] wd = 32'h0, rdat, q;
	int bad_count = 0, n_checks = 0, cyc = 0, n;
	// half period of the 40 MHz clock
	always #12.5 clk_i = ~clk_i;
	hpds_field i_field (.clk_i(clk_i), .nrst_i(nrst_i), .want_i(want), .frost_i(frost),
		.melt_i(melt), .short_i(shrt), .loads_i(loads), .calls_o(calls), .coil_o(coil),
		.short_o(spin));
	hpds_sequencer #(.TICK_CYC(TC)) i_dut (.clk_i(clk_i), .nrst_i(nrst_i), .calls_i(calls),
		.coil_frost_switch_i(coil), .run_period_sel_a_i(sel_a), .run_period_sel_b_i(sel_b),
		.two_comp_sel_i(two), .speedup_short_i(spin), .loads_o(loads), .avs_address_i(adr),
		.avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(be),
		.avs_readdata_o(rdat), .avs_waitrequest_o(wt));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic finish_test();
		if (bad_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic cycles(input int k);
		repeat (k) @(posedge clk_i);
	endtask
	// one avalon access; request held until waitrequest is sampled low at an edge
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_i);
		rd <= !w;
		wr <= w;
		adr <= a;
		wd <= d;
		@(posedge clk_i);
		while (wt !== 1'b0) begin
			@(posedge clk_i);
		end
		q = rdat;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask
	task automatic rdchk(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(q & m, e);
	endtask
	// loads follow inputs through synchronisers, so allow a bounded wait
	task automatic wait_ld(input logic [4:0] e, input int lim);
		n = 0;
		@(posedge clk_i);
		while (loads !== e && n < lim) begin
			@(posedge clk_i);
			n++;
		end
		chk(loads, e);
	endtask
	task automatic dur(input logic [4:0] e);
		n = 0;
		while (loads === e && n < 2000) begin
			@(posedge clk_i);
			n++;
		end
	endtask
	task automatic short_for(input int k);
		@(posedge clk_i);
		shrt <= 1'b1;
		cycles(k);
		shrt <= 1'b0;
	endtask
	task automatic s_regs();
		chk(loads, 5'h00);
		rdchk(4'h0, 32'h1, 32'h1);
		be <= 4'h0;
		bus(1'b1, 4'h0, 32'h0);
		be <= 4'hF;
		rdchk(4'h0, 32'h1, 32'h1);
		bus(1'b1, 4'h4, 32'hFFFFFFFF);
		rdchk(4'h4, 32'hC00, 32'h0);
		rdchk(4'hC, 32'hFFFFFFFF, 32'h0);
	endtask
	task automatic s_keep();
		want <= 4'h2;
		cycles(2500);
		want <= 4'h0;
		cycles(20);
		rdchk(4'h8, 32'hFF, 32'h2);
		cycles(1500);
		rdchk(4'h8, 32'hFF, 32'h2);
		want <= 4'h2;
		cycles(1300);
		rdchk(4'h8, 32'hFF, 32'h3);
	endtask
	task automatic s_modes();
		want <= 4'h8;
		wait_ld(5'h16, 20);
		two <= 1'b1;
		want <= 4'hC;
		wait_ld(5'h1E, 20);
		two <= 1'b0;
		wait_ld(5'h16, 20);
		want <= 4'h0;
		wait_ld(5'h02, 20);
		want <= 4'h2;
		wait_ld(5'h14, 20);
		want <= 4'h3;
		wait_ld(5'h15, 20);
		want <= 4'h0;
		wait_ld(5'h00, 20);
		want <= 4'h2;
		bus(1'b1, 4'h0, 32'h0);
		wait_ld(5'h00, 20);
		bus(1'b1, 4'h0, 32'h1);
		wait_ld(5'h14, 20);
	endtask
	task automatic s_sel();
		logic [7:0] tab [4] = '{8'h3C, 8'h1E, 8'h5A, 8'h78};
		for (int i = 0; i < 4; i++) begin
			sel_b <= i[1];
			sel_a <= i[0];
			cycles(6);
			rdchk(4'h8, 32'hFF00, {16'h0, tab[i], 8'h00});
		end
		sel_b <= 1'b0;
		sel_a <= 1'b0;
	endtask
	// scaled run: 60 ticks of period, defrost capped at 10 ticks
	task automatic s_test();
		short_for(20 * TC);
		cycles(100);
		chk(loads, 5'h14);
		rdchk(4'h4, 32'h200, 32'h200);
		cycles(60);
		chk(loads, 5'h14);
		frost <= 1'b1;
		wait_ld(5'h13, 140);
		dur(5'h13);
		chk(n >= 16 && n <= 24, 1);
		chk(loads, 5'h14);
		rdchk(4'h4, 32'h200, 32'h0);
		rdchk(4'h8, 32'hFF, 32'h0);
	endtask
	task automatic s_force(input logic f, input int lo, input int hi);
		frost <= f;
		melt <= 16'h0064;
		cycles(6);
		short_for(60 * TC);
		wait_ld(5'h13, 20);
		dur(5'h13);
		chk(n >= lo && n <= hi, 1);
		chk(loads, 5'h14);
		rdchk(4'h4, 32'h180, 32'h0);
	endtask
	// reset held six cycles, then the scenarios in turn
	initial begin
		cycles(6);
		nrst_i <= 1'b1;
		s_regs();
		s_keep();
		s_modes();
		s_sel();
		s_test();
		s_force(1'b0, 594, 606);
		s_force(1'b1, 95, 115);
		finish_test();
	end
	// run should need well under half of this
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			$display("[ERR] %0t timeout", $time);
			finish_test();
		end
	end
endmodule
